/* testbench/sspra_checker.sv */
// Assertions on the SPI wires between the host and sensor ends
`timescale 1ns/1ns
module sspra_checker (
    input wire logic ref_clk,   // Block clock
    input wire logic rst,       // Async reset, active high
    input wire logic cs_n,      // Chip select, active low
    input wire logic sclk,      // Serial clock
    input wire logic mosi,      // Host to device data
    input wire logic miso_o,    // Device output value
    input wire logic miso_oe_n, // Device output enable, active low
    input wire logic miso       // Resolved line
);
    logic [5:0] edge_cnt_q; // Rising sclk edges in frame
    logic       sclk_q;     // Previous sclk sample
    ////////////////////////////////////////////////////////////////////////////////
    // Count sclk rises while selected
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edge_cnt_q <= 6'h00;
            sclk_q     <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                edge_cnt_q <= 6'h00;                  // Idle clears count
            end else if (sclk && !sclk_q) begin
                edge_cnt_q <= edge_cnt_q + 6'h01;     // One more edge
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Wire rules
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_out_off_idle : assert property (cs_n [*4] |-> miso_oe_n)
        else $error("output driven while deselected");
    a_clk_idle_low : assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("sclk high outside frame");
    a_frame_sixteen : assert property ($rose(cs_n) |-> edge_cnt_q == 6'h10)
        else $error("frame edge count not sixteen");
    a_select_first : assert property ($fell(cs_n) |-> !sclk [*2])
        else $error("sclk high at frame start");
    a_clk_half_len : assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("sclk high phase length wrong");
    a_drive_in_frame : assert property ($fell(cs_n) |-> ##[1:6] !miso_oe_n)
        else $error("device output not enabled in frame");
    a_mosi_hold : assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("mosi changed while sclk high");
    a_miso_resolve : assert property (!miso_oe_n |-> miso == miso_o)
        else $error("resolved line differs from output");
endmodule : sspra_checker

/* testbench/tb.sv */
// Self-checking bench for the host and sensor ends joined by SPI
`timescale 1ns/1ns
module tb;
    logic        ref_clk;     // Block clock
    logic        rst;         // Reset, active high
    logic        psel;        // APB select
    logic        penable;     // APB enable
    logic        pwrite;      // APB direction
    logic [7:0]  paddr;       // APB address
    logic [31:0] pwdata;      // APB write data
    logic [31:0] prdata;      // APB read data
    logic        pready;      // APB ready
    logic        pslverr;     // APB error
    logic [13:0] rate_in;     // Rate source
    logic [11:0] supply_in;   // Supply source
    logic [11:0] extra_in;    // Extra analog source
    logic [11:0] temp_in;     // Temperature source
    logic        alarm_in;    // Alarm level
    logic        null_cmd;    // Angle clear pulse
    logic        flash_write; // Flash write pulse
    logic [7:0]  wr_data;     // Written byte
    logic [5:0]  wr_addr;     // Written byte address
    logic        wr_strobe;   // Write frame pulse
    int          failures;    // Mismatch count
    int          checks;      // Comparison count
    int          cyc;         // Timeout counter
    int          strobes;     // Write pulses seen
    sspra_if spi_bus ();      // Link between ends
    sspra_host u_sspra_host (.ref_clk(ref_clk), .rst(rst), .spi(spi_bus), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sspra_device #(.SAMPLE_PERIOD(4)) u_sspra_device (.ref_clk(ref_clk), .rst(rst),
        .spi(spi_bus), .rate_in(rate_in), .supply_in(supply_in), .extra_in(extra_in),
        .temp_in(temp_in), .alarm_in(alarm_in), .null_cmd(null_cmd),
        .flash_write(flash_write), .wr_data(wr_data), .wr_addr(wr_addr),
        .wr_strobe(wr_strobe));
    sspra_checker u_sspra_checker (.ref_clk(ref_clk), .rst(rst), .cs_n(spi_bus.cs_n),
        .sclk(spi_bus.sclk), .mosi(spi_bus.mosi), .miso_o(spi_bus.miso_o),
        .miso_oe_n(spi_bus.miso_oe_n), .miso(spi_bus.miso));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    // APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One frame: send word, wait idle, return received word
    task frame(input logic [15:0] word, output logic [15:0] got);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b1, 8'h00, {16'h0000, word}, r, e);
        chk({31'h0, e}, 32'h0);
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        chk({31'h0, r[0]}, 32'h0);
        got = r[31:16];
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_idle;
        chk({31'h0, spi_bus.miso_oe_n}, 32'h1);
    endtask : t_idle
    // Chained reads, odd addresses, junk tail bits
    task t_reads;
        logic [15:0] req [5];
        logic [15:0] exp [5];
        logic [15:0] got;
        req = '{16'h04a5, 16'h03ff, 16'h0c00, 16'h0b5a, 16'h0000};
        exp = '{16'he000, 16'hc9ab, 16'hc801, 16'hcfff, 16'h0003};
        frame(req[0], got);
        for (int i = 1; i < 5; i++) begin
            frame(req[i], got);
            chk({16'h0, got}, {16'h0, exp[i-1]});
        end
        frame(16'h0e33, got);
        chk({16'h0, got}, {16'h0, exp[4]});
        chk(strobes, 32'h0);
    endtask : t_reads
    task t_write;
        logic [15:0] got;
        frame(16'ha15a, got);
        chk(strobes, 32'h1);
        chk({26'h0, wr_addr}, 32'h21);
        chk({24'h0, wr_data}, 32'h5a);
        frame(16'ha0c3, got);
        chk(strobes, 32'h2);
        chk({26'h0, wr_addr}, 32'h20);
        chk({24'h0, wr_data}, 32'hc3);
    endtask : t_write
    // Busy write and unmapped address refused
    task t_refuse;
        logic [31:0] r;
        logic        e;
        logic [15:0] got;
        apb(1'b1, 8'h00, 32'h000004a5, r, e);
        chk({31'h0, e}, 32'h0);
        apb(1'b1, 8'h00, 32'h000004a5, r, e);
        chk({31'h0, e}, 32'h1);
        do apb(1'b0, 8'h04, 32'h0, r, e); while (r[0] !== 1'b0);
        frame(16'h0000, got);
        chk({16'h0, got}, 32'h0000e000);
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask : t_refuse
    // Angle cleared by null pulse, stays zero with zero rate
    task t_null;
        logic [15:0] got;
        @(posedge ref_clk);
        rate_in  <= 14'h0000;
        null_cmd <= 1'b1;
        @(posedge ref_clk);
        null_cmd <= 1'b0;
        frame(16'h0e00, got);
        frame(16'h0000, got);
        chk({16'h0, got}, 32'h0000c000);
    endtask : t_null
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, timeout, write pulse count
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (wr_strobe === 1'b1) strobes++;
        if (cyc == 30000) begin
            failures++;
            end_of_test;
        end
    end
    // Main sequence
    initial begin
        {failures, checks, cyc, strobes} = '0;
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        rate_in     = 14'h2000; // Most negative rate code
        supply_in   = 12'h9ab;
        extra_in    = 12'hfff;
        temp_in     = 12'h801;
        alarm_in    = 1'b1;
        null_cmd    = 1'b0;
        flash_write = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) begin
            @(posedge ref_clk) flash_write <= 1'b1;
            @(posedge ref_clk) flash_write <= 1'b0;
        end
        t_idle;
        t_reads;
        t_write;
        t_refuse;
        t_null;
        end_of_test;
    end
endmodule : tb

/* verilog/sspra_device.sv */
// Sensor end: SPI slave with read-only output data registers
//
// Notes on behaviour
// (RULE1) Registers 16 bits, two 6-bit byte addresses
// (RULE2) Chip select high: output off, link ignored
// (RULE3) Frames are exactly 16 clocks under select
// (RULE4) Full duplex, 16 bits each way
// (RULE5) Write frame: 1,0,address,8 data bits
// (RULE6) Host writes each byte in own frame
// (RULE7) Read request: 0,0 then address
// (RULE8) Either byte address returns whole register
// (RULE9) Last 8 bits of read ignored
// (RULE10) Read data returned in next frame
// (RULE11) Next request accepted while returning data
// (RULE12) Outputs refresh independent of host reads
// (RULE13) Bit 15 new data, cleared on read
// (RULE14) Bit 14 error or alarm flag
// (RULE15) 12-bit data: bits 13:12 don't care
// (RULE16) Rate is 14-bit two's complement
// (RULE17) Temperature 12-bit two's complement
// (RULE18) Extra analog input 12-bit straight binary
// (RULE19) Flash write count full 16 bits
// (RULE20) Angle cleared on null, reset, power-up
// (RULE21) Bits shifted most significant first
//
// The link pins are sampled by ref_clk through two flip-flops, so each
// half period of the link clock must span at least four ref_clk cycles.
`timescale 1ns/1ns
`include "sspra_params.svh"
module sspra_device #(
    parameter int SAMPLE_PERIOD = `SSPRA_SAMPLE_PERIOD    // Internal refresh period in clocks
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    sspra_if.dev             spi,
    input  wire logic [13:0] rate_in,          // Rate sample source
    input  wire logic [11:0] supply_in,        // Supply sample source
    input  wire logic [11:0] extra_in,         // Extra analog sample source
    input  wire logic [11:0] temp_in,          // Temperature sample source
    input  wire logic        alarm_in,         // System error or alarm level
    input  wire logic        null_cmd,         // Bias null pulse, clears angle
    input  wire logic        flash_write,      // One pulse per flash write
    output logic [7:0]       wr_data,          // Last written byte
    output logic [5:0]       wr_addr,          // Its byte address
    output logic             wr_strobe         // Pulse per write frame
);
    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [1:0]  cs_s;                 // Select synchroniser, bit1 is second stage
        logic [1:0]  sck_s;                // Link clock synchroniser
        logic [1:0]  mosi_s;               // Serial input synchroniser
        logic        sck_prev;             // Last synced clock, for edge detect
        logic [4:0]  bit_cnt;              // Bits received this frame
        logic [15:0] rx;                   // Receive shift
        logic [15:0] tx;                   // Transmit shift
        logic [5:0]  rd_addr;              // Pending read address
        logic        rd_pend;              // Read requested last frame
        logic [15:0] tmr;                  // Refresh timer
        logic [5:0]  new_sample_flag;      // New data flags per register
        logic [15:0] flash_cnt;            // Flash write count
        logic [13:0] rate;                 // Latest rate sample
        logic [13:0] angle;                // Integrated rate
        logic [11:0] supply;               // Latest supply sample
        logic [11:0] extra;                // Latest extra analog sample
        logic [11:0] temp;                 // Latest temperature sample
        logic        miso_o;               // Serial output value
        logic        miso_oe_n;            // Serial output enable, active low
        logic [7:0]  wdat;                 // Last written byte
        logic [5:0]  wadr;                 // Its byte address
        logic        wstb;                 // Write frame pulse
    } sspra_dstate_t;
    sspra_dstate_t q, d;

    // Register index from a byte address, word-aligned [RULE1] [RULE8]
    function automatic logic [2:0] sspra_idx(input logic [5:0] a);
        case ({a[5:1], 1'b0})
            `SSPRA_OFF_FLASH_CNT: sspra_idx = 3'h0;
            `SSPRA_OFF_SUPPLY:    sspra_idx = 3'h1;
            `SSPRA_OFF_RATE:      sspra_idx = 3'h2;
            `SSPRA_OFF_EXTRA:     sspra_idx = 3'h3;
            `SSPRA_OFF_TEMP:      sspra_idx = 3'h4;
            `SSPRA_OFF_ANGLE:     sspra_idx = 3'h5;
            default:              sspra_idx = 3'h7;
        endcase
    endfunction : sspra_idx

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [2:0]  ix;
        logic [15:0] word;
        logic        rise, fall;
        logic        refresh;
        // Defaults for the read path
        ix      = 3'h7;
        word    = 16'h0000;
        refresh = 1'b0;
        d = q;
        // Pins pass two flip-flops before any logic reads them
        d.cs_s   = {q.cs_s[0], spi.cs_n};
        d.sck_s  = {q.sck_s[0], spi.sclk};
        d.mosi_s = {q.mosi_s[0], spi.mosi};
        d.sck_prev = q.sck_s[1];
        d.wstb = 1'b0;
        // Edges found on the second stage only
        rise = q.sck_s[1] & ~q.sck_prev;
        fall = ~q.sck_s[1] & q.sck_prev;
        // Internal refresh, unrelated to host traffic [RULE12]
        refresh = (q.tmr >= 16'(SAMPLE_PERIOD - 1));
        if (refresh) begin
            d.tmr    = 16'h0000;
            d.rate   = rate_in;                        // [RULE16]
            d.supply = supply_in;
            d.extra  = extra_in;                       // [RULE18]
            d.temp   = temp_in;                        // [RULE17]
            d.angle  = q.angle + rate_in;              // Integrate rate
            d.new_sample_flag = 6'h3f;                 // [RULE13]
        end else begin
            d.tmr = q.tmr + 16'h0001;
        end
        // Flash write count, one per pulse
        if (flash_write) begin
            d.flash_cnt = q.flash_cnt + 16'h0001;      // [RULE19]
            d.new_sample_flag[0] = 1'b1;
        end
        // Bias null clears the angle
        if (null_cmd) begin
            d.angle = 14'h0000;                        // [RULE20]
        end
        // Frame logic, active only under select
        if (q.cs_s[1]) begin
            // Deselected: tristate, restart frame [RULE2]
            d.miso_oe_n = 1'b1;
            d.bit_cnt   = 5'd0;
        end else begin
            d.miso_oe_n = 1'b0;
            // Hold the first bit ready before the first edge
            if (q.bit_cnt == 5'd0 && !rise) begin
                d.miso_o = q.tx[15];                   // First bit out, MSB [RULE21]
            end
            if (rise) begin
                // Sample input, full duplex [RULE4]
                d.rx      = {q.rx[14:0], q.mosi_s[1]};
                d.bit_cnt = q.bit_cnt + 5'd1;
                d.tx      = {q.tx[14:0], 1'b0};
                if (q.bit_cnt == `SSPRA_FRAME_BITS - 5'd1) begin
                    // Frame complete after 16 clocks [RULE3]
                    d.bit_cnt = 5'd0;
                    d.rd_pend = 1'b0;
                    if (q.rx[14]) begin
                        // Write: 1,0,address,data [RULE5]
                        d.wadr = q.rx[12:7];
                        d.wdat = {q.rx[6:0], q.mosi_s[1]};
                        d.wstb = 1'b1;
                    end else if (!q.rx[13]) begin
                        // Read: 0,0,address; data bits dropped [RULE7] [RULE9]
                        d.rd_addr = q.rx[12:7];
                        d.rd_pend = 1'b1;
                        ix = sspra_idx(q.rx[12:7]);
                        case (ix)
                            3'h0:    word = q.flash_cnt;
                            3'h1:    word = {2'b00, 2'b00, q.supply};     // [RULE15]
                            3'h2:    word = {2'b00, q.rate};
                            3'h3:    word = {2'b00, 2'b00, q.extra};
                            3'h4:    word = {2'b00, 2'b00, q.temp};
                            3'h5:    word = {2'b00, q.angle};
                            default: word = 16'h0000;
                        endcase
                        // Flash word carries no flags; all 16 bits count
                        if (ix != 3'h0 && ix != 3'h7) begin
                            word[`SSPRA_BIT_NEW] = q.new_sample_flag[ix]; // [RULE13]
                            word[`SSPRA_BIT_ERR] = alarm_in;              // [RULE14]
                        end
                        // Read clears its flag, a fresh load in the same cycle wins
                        if (ix != 3'h7 && !refresh && !(ix == 3'h0 && flash_write)) begin
                            d.new_sample_flag[ix] = 1'b0;
                        end
                        d.tx = word;               // Loaded for next frame [RULE10] [RULE11]
                    end
                end
            end
            // Output changes on the falling edge, host samples before the next
            if (fall) begin
                d.miso_o = q.tx[15];               // Shift out MSB first [RULE21]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    // Asynchronous reset to idle, serial output released
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.cs_s <= 2'b11;
            q.miso_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register
    assign spi.miso_o    = q.miso_o;
    assign spi.miso_oe_n = q.miso_oe_n;
    assign wr_data   = q.wdat;
    assign wr_addr   = q.wadr;
    assign wr_strobe = q.wstb;
endmodule : sspra_device

/* verilog/sspra_host.sv */
// Host end: APB-controlled SPI master for the sensor link
`timescale 1ns/1ns
`include "sspra_params.svh"
module sspra_host #(
    parameter logic [3:0] SCLK_DIV = `SSPRA_SCLK_DIV  // Clocks per half sclk period
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    sspra_if.host            spi,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    // 0x00 write: start frame with word [15:0]; 0x04 read: bit0 busy,
    // [31:16] last received word
    typedef struct packed {
        logic [1:0]  miso_s;
        sspra_pkg::sspra_hstate_t st;
        logic [3:0]  div;
        logic [4:0]  cnt;
        logic [15:0] tx, rx, last;
        logic        cs_n, sclk, mosi;
        logic [31:0] prdata;
        logic        pready, pslverr;
    } sspra_hst_t;
    sspra_hst_t q, d;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        d.miso_s = {q.miso_s[0], spi.miso};
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        // APB: one wait state, answer in access phase
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            if (paddr == 8'h00 && pwrite) begin
                if (q.st == sspra_pkg::SSPRA_H_IDLE) begin
                    d.tx = pwdata[15:0];
                    d.st = sspra_pkg::SSPRA_H_LOW;
                    d.cs_n = 1'b0;
                    d.mosi = pwdata[15];       // MSB first [RULE21]
                    d.cnt = 5'd0;
                    d.div = 4'h0;
                end else begin
                    d.pslverr = 1'b1;          // Busy
                end
            end else if (paddr == 8'h04 && !pwrite) begin
                d.prdata = {q.last, 15'h0000, q.st != sspra_pkg::SSPRA_H_IDLE};
            end else begin
                d.pslverr = 1'b1;
            end
        end
        case (q.st)
            sspra_pkg::SSPRA_H_IDLE: d.sclk = 1'b0;
            sspra_pkg::SSPRA_H_LOW: begin
                d.div = q.div + 4'h1;
                if (q.div == SCLK_DIV - 4'h1) begin
                    d.div = 4'h0;
                    d.sclk = 1'b1;
                    d.st = sspra_pkg::SSPRA_H_HIGH;
                end
            end
            sspra_pkg::SSPRA_H_HIGH: begin
                d.div = q.div + 4'h1;
                if (q.div == SCLK_DIV - 4'h1) begin
                    d.div = 4'h0;
                    d.sclk = 1'b0;
                    d.tx = {q.tx[14:0], 1'b0};
                    // Sample late: the reply crosses two flip-flops each way
                    d.rx = {q.rx[14:0], q.miso_s[1]};
                    d.mosi = q.tx[14];
                    d.cnt = q.cnt + 5'd1;
                    // Always 16 full clocks per frame [RULE3]
                    d.st = (q.cnt == `SSPRA_FRAME_BITS - 5'd1) ?
                           sspra_pkg::SSPRA_H_DONE : sspra_pkg::SSPRA_H_LOW;
                end
            end
            sspra_pkg::SSPRA_H_DONE: begin
                d.div = q.div + 4'h1;
                if (q.div == SCLK_DIV - 4'h1) begin
                    d.cs_n = 1'b1;
                    d.last = q.rx;
                    d.st = sspra_pkg::SSPRA_H_IDLE;
                end
            end
            default: d.st = sspra_pkg::SSPRA_H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign spi.cs_n = q.cs_n;
    assign spi.sclk = q.sclk;
    assign spi.mosi = q.mosi;
    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;
endmodule : sspra_host

/* verilog/sspra_if.sv */
// Four-wire SPI link between host and sensor
`timescale 1ns/1ns
interface sspra_if;
    logic cs_n;      // Chip select, active low
    logic sclk;      // Serial clock from host
    logic mosi;      // Host to device data
    logic miso_o;    // Device output value
    logic miso_oe_n; // Device output enable, active low
    logic miso;      // Resolved line
    // Released line shows the inverse, so a sample taken off-frame is caught
    assign miso = miso_oe_n ? ~miso_o : miso_o;
    modport dev  (input cs_n, input sclk, input mosi, output miso_o, output miso_oe_n);
    modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : sspra_if

/* verilog/sspra_params.svh */
// Constants for the sensor SPI register access block
`ifndef SSPRA_PARAMS_SVH
`define SSPRA_PARAMS_SVH
`define SSPRA_FRAME_BITS      5'd16
`define SSPRA_ADDR_W          6
`define SSPRA_OFF_FLASH_CNT   6'h00
`define SSPRA_OFF_SUPPLY      6'h02
`define SSPRA_OFF_RATE        6'h04
`define SSPRA_OFF_EXTRA       6'h0a
`define SSPRA_OFF_TEMP        6'h0c
`define SSPRA_OFF_ANGLE       6'h0e
`define SSPRA_BIT_NEW         15
`define SSPRA_BIT_ERR         14
`define SSPRA_SCLK_DIV        4'd4
`define SSPRA_SAMPLE_PERIOD   16'h0100
`endif

/* verilog/sspra_pkg.sv */
// Types for the host end of the sensor SPI link
package sspra_pkg;
    typedef enum logic [1:0] {
        SSPRA_H_IDLE = 2'b00,
        SSPRA_H_LOW  = 2'b01,
        SSPRA_H_HIGH = 2'b11,
        SSPRA_H_DONE = 2'b10
    } sspra_hstate_t;
endpackage : sspra_pkg
